// ---- core/regulator_cfg_pkg.sv ----
// Constants for the regulator configuration command bank.
// Assumes a command decoder that presents whole PMBus commands per cycle.
package regulator_cfg_pkg;
    // Command codes
    localparam logic [7:0] CMD_TUNING_CONFIG   = 8'hBC;
    localparam logic [7:0] CMD_TUNING_TRIGGER  = 8'hBD;
    localparam logic [7:0] CMD_DEADTIME_LIMITS = 8'hBF;
    localparam logic [7:0] CMD_SENSE_PIN_CFG   = 8'hD0;
    localparam logic [7:0] CMD_OPERATING_OPTS  = 8'hD1;
    localparam logic [7:0] CMD_SHARE_RAIL_CFG  = 8'hD2;
    // Reset values
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0]  RESET_BYTE = 8'h00;
    // tuning_config fields
    localparam int TC_GAIN_LSB   = 4;
    localparam int TC_PG_SEL     = 3;
    localparam int TC_RETAIN     = 2;
    localparam int TC_MODE_LSB   = 0;
    localparam logic [3:0] GAIN_CODE_MAX = 4'h9;
    localparam logic [6:0] GAIN_STEP_PCT = 7'h0A;
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_ONCE   = 2'h1;
    localparam logic [1:0] MODE_SECOND = 2'h2;
    localparam logic [1:0] MODE_MINUTE = 2'h3;
    // sense_and_pin_config fields
    localparam int SP_BLANK_LSB  = 11;
    localparam int SP_COUNT_LSB  = 8;
    localparam int SP_METHOD_LSB = 4;
    localparam int SP_NLR_ALWAYS = 3;
    localparam int SP_PG_PUSH    = 1;
    localparam int SP_SYNC_PUSH  = 0;
    localparam logic [9:0] BLANK_STEP_NS = 10'h020;
    localparam logic [1:0] METHOD_RESERVED = 2'h3;
    localparam logic [1:0] METHOD_DEFAULT  = 2'h0;
    // operating_options fields
    localparam int OP_DUTY_LSB    = 14;
    localparam int OP_DUTY_EN     = 13;
    localparam int OP_HIZ_DOWN    = 12;
    localparam int OP_SYNC_TMO    = 11;
    localparam int OP_NO_FFWD     = 9;
    localparam int OP_SPREAD      = 8;
    localparam int OP_EXT_CLK     = 6;
    localparam int OP_SYNC_OUT    = 5;
    localparam int OP_LOWSIDE_ON  = 2;
    localparam int OP_STANDBY_LSB = 0;
    localparam logic [1:0] STANDBY_LOW_POWER = 2'h0;
    localparam logic [1:0] STANDBY_RESERVED  = 2'h2;
    // share_rail_config fields
    localparam int SR_ID_LSB     = 8;
    localparam int SR_COUNT_LSB  = 5;
    localparam int SR_POS_LSB    = 2;
    localparam int SR_MEMBER     = 0;
    // Timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SYNC_OFF_MS     = 500;
    localparam int SECOND_MS       = 1000;
    localparam int MINUTE_S        = 60;
    localparam int SYNC_OFF_CYCLES = SYNC_OFF_MS * (1000000 / CLK_PERIOD_NS);
    localparam int SECOND_CYCLES   = SECOND_MS * (1000000 / CLK_PERIOD_NS);
endpackage

// ---- core/regulator_cfg.sv ----
// Configuration command bank of a point-of-load regulator core.
// Assumes a decoded PMBus command stream and core status inputs, all synchronous to core_clk.
//
// Overview of operation
// R1: Gain of tuning results scaled 10% to 100% by config bits 7:4.
// R2: Config bit 3 picks power-good after delay or after tuning completes.
// R3: Bit 2 clear reruns tuning each ramp; set runs it once per power-up.
// R4: Mode bits: off, once after ramp, every second or every minute while the share membership bit is clear.
// R5: Send-byte trigger starts tuning only while tuning mode is enabled.
// R6: Dead-time word holds two signed nanosecond limits, high-to-low and low-to-high.
// R7: Current-sense blanking equals bits 15:11 times 32 ns.
// R8: Current fault after 2n+1 consecutive violations, n from bits 10:8.
// R9: Bits 5:4 choose current-sensing method.
// R10: Bit 3 set keeps transient response always on, else waits for power-good.
// R11: Bit 1 and bit 0 pick push-pull or open-drain for two pins.
// R12: Bit 13 enables ramp minimum duty of (code+1)/256 period.
// R13: Bit 12 holds output high-impedance during ramp-down until undervoltage.
// R14: Bit 11 stops driving switch clock 500 ms after disable.
// R15: Bit 9 set disables input-voltage correction of filter coefficients.
// R16: Bit 8 set makes any grouped device fault shut this device down.
// R17: Bit 6 selects external clock input instead of auto-configuration.
// R18: Bit 5 drives internal switch clock out on the pin.
// R19: Bit 2 turns low-side drive on while disabled.
// R20: Standby mode bits; low power makes measurement reads a logic fault.
// R21: Host programs share-rail ID 0 to 31 matching group bus ID.
// R22: Share config holds member count, position and membership bit.
// R23: Undefined bits and reserved codes are stored but ignored.
`timescale 1ns/1ps
`default_nettype none
module regulator_cfg #(
    parameter int SYNC_OFF_CYCLES = regulator_cfg_pkg::SYNC_OFF_CYCLES,
    parameter int SECOND_CYCLES   = regulator_cfg_pkg::SECOND_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic             rsp_valid,
    output logic [15:0]      rsp_rdata,
    output logic             cmd_unsupported,
    input  wire logic        device_enabled,
    input  wire logic        ramp_up_done,
    input  wire logic        in_ramp,
    input  wire logic        ramping_down,
    input  wire logic        below_uv_threshold,
    input  wire logic        pg_delay_done,
    input  wire logic        tuning_done,
    input  wire logic        sense_strobe,
    input  wire logic        sense_violation,
    input  wire logic        group_fault,
    input  wire logic        int_switch_clk,
    input  wire logic        meas_read,
    output logic             tuning_start,
    output logic [6:0]       tuning_gain_pct,
    output logic [7:0]       deadtime_hl_ns,
    output logic [7:0]       deadtime_lh_ns,
    output logic [9:0]       blank_delay_ns,
    output logic             current_fault,
    output logic [1:0]       sense_method,
    output logic             nonlinear_transient_response,
    output logic             output_ok_pin_out,
    output logic             output_ok_pin_oe,
    output logic             sync_pin_out,
    output logic             sync_pin_oe,
    output logic [2:0]       min_duty_num,
    output logic             min_duty_active,
    output logic             output_hiz,
    output logic             vin_correction_on,
    output logic             shutdown_request,
    output logic             use_ext_clock,
    output logic             lowside_drive_on,
    output logic [1:0]       standby_mode,
    output logic             comm_logic_fault,
    output logic [7:0]       share_id,
    output logic [2:0]       share_count_m1,
    output logic [2:0]       share_pos_m1,
    output logic             share_member
);
    logic        rst_meta;
    logic        rst_sync_n;
    logic [7:0]  tuning_config;
    logic [15:0] deadtime_upper_limits;
    logic [15:0] sense_and_pin_config;
    logic [15:0] operating_options;
    logic [15:0] share_rail_config;
    logic        results_valid;
    logic        pg_ready;
    logic [31:0] tick_cnt;
    logic [5:0]  sec_cnt;
    logic [31:0] sync_off_cnt;
    logic        sync_timed_out;
    logic [3:0]  viol_run;
    logic        wr;
    logic [1:0]  mode;
    logic        periodic_due;
    logic        next_tune;
    logic [3:0]  fault_need;
    logic        sync_drive;

    // Reset release through two flip-flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    assign wr   = cmd_valid && cmd_write;
    assign mode = tuning_config[regulator_cfg_pkg::TC_MODE_LSB +: 2];

    // Register writes; every bit stored as written
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tuning_config         <= regulator_cfg_pkg::RESET_BYTE;
            deadtime_upper_limits <= regulator_cfg_pkg::RESET_WORD;
            sense_and_pin_config  <= regulator_cfg_pkg::RESET_WORD;
            operating_options     <= regulator_cfg_pkg::RESET_WORD;
            share_rail_config     <= regulator_cfg_pkg::RESET_WORD;
        end else if (wr) begin
            case (cmd_code)
                regulator_cfg_pkg::CMD_TUNING_CONFIG:   tuning_config <= cmd_wdata[7:0]; // [R23]
                regulator_cfg_pkg::CMD_DEADTIME_LIMITS: deadtime_upper_limits <= cmd_wdata;
                regulator_cfg_pkg::CMD_SENSE_PIN_CFG:   sense_and_pin_config <= cmd_wdata;
                regulator_cfg_pkg::CMD_OPERATING_OPTS:  operating_options <= cmd_wdata;
                regulator_cfg_pkg::CMD_SHARE_RAIL_CFG:  share_rail_config <= cmd_wdata;
                default: ;
            endcase
        end
    end

    // Read answers and unsupported commands
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rsp_valid       <= 1'b0;
            rsp_rdata       <= 16'h0000;
            cmd_unsupported <= 1'b0;
        end else begin
            rsp_valid       <= cmd_valid && !cmd_write;
            cmd_unsupported <= 1'b0;
            rsp_rdata       <= 16'h0000;
            if (cmd_valid) begin
                case (cmd_code)
                    regulator_cfg_pkg::CMD_TUNING_CONFIG:   rsp_rdata <= {8'h00, tuning_config};
                    regulator_cfg_pkg::CMD_TUNING_TRIGGER:  cmd_unsupported <= !cmd_write;
                    regulator_cfg_pkg::CMD_DEADTIME_LIMITS: rsp_rdata <= deadtime_upper_limits;
                    regulator_cfg_pkg::CMD_SENSE_PIN_CFG:   rsp_rdata <= sense_and_pin_config;
                    regulator_cfg_pkg::CMD_OPERATING_OPTS:  rsp_rdata <= operating_options;
                    regulator_cfg_pkg::CMD_SHARE_RAIL_CFG:  rsp_rdata <= share_rail_config;
                    default: cmd_unsupported <= 1'b1;
                endcase
            end
        end
    end

    // Periodic tuning timers, run only while enabled in a periodic mode; share membership masks the due pulse
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tick_cnt <= 32'h00000000;
            sec_cnt  <= 6'h00;
        end else if (!device_enabled || mode[1] == 1'b0) begin
            tick_cnt <= 32'h00000000;
            sec_cnt  <= 6'h00;
        end else if (tick_cnt == 32'(SECOND_CYCLES - 1)) begin
            tick_cnt <= 32'h00000000;
            sec_cnt  <= (sec_cnt == 6'(regulator_cfg_pkg::MINUTE_S - 1)) ? 6'h00 : sec_cnt + 6'h01;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
        end
    end

    always_comb begin
        periodic_due = 1'b0;
        if (tick_cnt == 32'(SECOND_CYCLES - 1) && !share_rail_config[regulator_cfg_pkg::SR_MEMBER]) begin
            if (mode == regulator_cfg_pkg::MODE_SECOND) periodic_due = 1'b1; // [R4]
            if (mode == regulator_cfg_pkg::MODE_MINUTE &&
                sec_cnt == 6'(regulator_cfg_pkg::MINUTE_S - 1)) periodic_due = 1'b1; // [R4]
        end
        next_tune = 1'b0;
        if (mode != regulator_cfg_pkg::MODE_OFF) begin
            if (wr && cmd_code == regulator_cfg_pkg::CMD_TUNING_TRIGGER) next_tune = 1'b1; // [R5]
            if (ramp_up_done &&
                !(tuning_config[regulator_cfg_pkg::TC_RETAIN] && results_valid)) next_tune = 1'b1; // [R3]
            if (periodic_due) next_tune = 1'b1;
        end
    end

    // Tuning start pulse and retained results
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tuning_start  <= 1'b0;
            results_valid <= 1'b0;
        end else begin
            tuning_start <= next_tune;
            if (tuning_done && tuning_config[regulator_cfg_pkg::TC_RETAIN]) results_valid <= 1'b1; // [R3]
        end
    end

    // Power-good readiness after ramp-up
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pg_ready <= 1'b0;
        end else if (!device_enabled) begin
            pg_ready <= 1'b0;
        end else if (tuning_config[regulator_cfg_pkg::TC_PG_SEL] &&
                     mode != regulator_cfg_pkg::MODE_OFF) begin
            if (tuning_done) pg_ready <= 1'b1; // [R2]
        end else if (pg_delay_done) begin
            pg_ready <= 1'b1; // [R2]
        end
    end

    // Consecutive current violation counting
    assign fault_need = {sense_and_pin_config[regulator_cfg_pkg::SP_COUNT_LSB +: 3], 1'b1};
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            viol_run      <= 4'h0;
            current_fault <= 1'b0;
        end else if (sense_strobe) begin
            if (!sense_violation) begin
                viol_run      <= 4'h0;
                current_fault <= 1'b0;
            end else begin
                if (viol_run != 4'hF) viol_run <= viol_run + 4'h1;
                if (viol_run + 4'h1 >= fault_need) current_fault <= 1'b1; // [R8]
            end
        end
    end

    // Switch clock time-out after disable
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sync_off_cnt   <= 32'h00000000;
            sync_timed_out <= 1'b0;
        end else if (device_enabled || !operating_options[regulator_cfg_pkg::OP_SYNC_TMO]) begin
            sync_off_cnt   <= 32'h00000000;
            sync_timed_out <= 1'b0;
        end else if (sync_off_cnt == 32'(SYNC_OFF_CYCLES - 1)) begin
            sync_timed_out <= 1'b1; // [R14]
        end else begin
            sync_off_cnt <= sync_off_cnt + 32'h00000001;
        end
    end

    assign sync_drive = operating_options[regulator_cfg_pkg::OP_SYNC_OUT] &&
                        !operating_options[regulator_cfg_pkg::OP_EXT_CLK] &&
                        !sync_timed_out;

    // Pin drivers
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            output_ok_pin_out <= 1'b0;
            output_ok_pin_oe  <= 1'b0;
            sync_pin_out      <= 1'b0;
            sync_pin_oe       <= 1'b0;
        end else begin
            output_ok_pin_out <= pg_ready;
            output_ok_pin_oe  <= sense_and_pin_config[regulator_cfg_pkg::SP_PG_PUSH] || !pg_ready; // [R11]
            sync_pin_out      <= int_switch_clk; // [R18]
            sync_pin_oe       <= sync_drive && (sense_and_pin_config[regulator_cfg_pkg::SP_SYNC_PUSH] ||
                                 !int_switch_clk); // [R11] [R14] [R18]
        end
    end

    // Core control outputs
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tuning_gain_pct              <= 7'h00;
            deadtime_hl_ns               <= 8'h00;
            deadtime_lh_ns               <= 8'h00;
            blank_delay_ns               <= 10'h000;
            sense_method                 <= regulator_cfg_pkg::METHOD_DEFAULT;
            nonlinear_transient_response <= 1'b0;
            min_duty_num                 <= 3'h0;
            min_duty_active              <= 1'b0;
            output_hiz                   <= 1'b0;
            vin_correction_on            <= 1'b1;
            shutdown_request             <= 1'b0;
            use_ext_clock                <= 1'b0;
            lowside_drive_on             <= 1'b0;
            standby_mode                 <= regulator_cfg_pkg::STANDBY_LOW_POWER;
            comm_logic_fault             <= 1'b0;
            share_id                     <= 8'h00;
            share_count_m1               <= 3'h0;
            share_pos_m1                 <= 3'h0;
            share_member                 <= 1'b0;
        end else begin
            if (tuning_config[regulator_cfg_pkg::TC_GAIN_LSB +: 4] <= regulator_cfg_pkg::GAIN_CODE_MAX)
                tuning_gain_pct <= 7'((tuning_config[regulator_cfg_pkg::TC_GAIN_LSB +: 4] + 4'h1) *
                                      regulator_cfg_pkg::GAIN_STEP_PCT); // [R1] [R23]
            deadtime_hl_ns <= deadtime_upper_limits[15:8]; // [R6]
            deadtime_lh_ns <= deadtime_upper_limits[7:0]; // [R6]
            blank_delay_ns <= 10'(sense_and_pin_config[regulator_cfg_pkg::SP_BLANK_LSB +: 5] *
                                  regulator_cfg_pkg::BLANK_STEP_NS); // [R7]
            if (sense_and_pin_config[regulator_cfg_pkg::SP_METHOD_LSB +: 2] !=
                regulator_cfg_pkg::METHOD_RESERVED)
                sense_method <= sense_and_pin_config[regulator_cfg_pkg::SP_METHOD_LSB +: 2]; // [R9]
            nonlinear_transient_response <= sense_and_pin_config[regulator_cfg_pkg::SP_NLR_ALWAYS] ||
                                            pg_ready; // [R10]
            min_duty_num    <= {1'b0, operating_options[regulator_cfg_pkg::OP_DUTY_LSB +: 2]} + 3'h1;
            min_duty_active <= operating_options[regulator_cfg_pkg::OP_DUTY_EN] && in_ramp; // [R12]
            output_hiz      <= operating_options[regulator_cfg_pkg::OP_HIZ_DOWN] && ramping_down &&
                               !below_uv_threshold; // [R13]
            vin_correction_on <= !operating_options[regulator_cfg_pkg::OP_NO_FFWD]; // [R15]
            shutdown_request  <= operating_options[regulator_cfg_pkg::OP_SPREAD] && group_fault; // [R16]
            use_ext_clock     <= operating_options[regulator_cfg_pkg::OP_EXT_CLK]; // [R17]
            lowside_drive_on  <= !device_enabled &&
                                 operating_options[regulator_cfg_pkg::OP_LOWSIDE_ON]; // [R19]
            if (operating_options[regulator_cfg_pkg::OP_STANDBY_LSB +: 2] !=
                regulator_cfg_pkg::STANDBY_RESERVED)
                standby_mode <= operating_options[regulator_cfg_pkg::OP_STANDBY_LSB +: 2]; // [R20]
            comm_logic_fault <= meas_read && !device_enabled &&
                                standby_mode == regulator_cfg_pkg::STANDBY_LOW_POWER; // [R20]
            share_id       <= share_rail_config[regulator_cfg_pkg::SR_ID_LSB +: 8]; // [R21]
            share_count_m1 <= share_rail_config[regulator_cfg_pkg::SR_COUNT_LSB +: 3]; // [R22]
            share_pos_m1   <= share_rail_config[regulator_cfg_pkg::SR_POS_LSB +: 3]; // [R22]
            share_member   <= share_rail_config[regulator_cfg_pkg::SR_MEMBER]; // [R22]
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    sequence trigger_cmd;
        wr && cmd_code == regulator_cfg_pkg::CMD_TUNING_TRIGGER;
    endsequence

    a_trigger_starts: assert property (trigger_cmd and
        (mode != regulator_cfg_pkg::MODE_OFF) |=> tuning_start) // [R5]
        else $error("tuning trigger did not start tuning");
    a_trigger_gated: assert property (tuning_start |->
        $past(mode) != regulator_cfg_pkg::MODE_OFF) // [R5]
        else $error("tuning started while disabled");
    a_gain_scale: assert property ($past(tuning_config[7:4]) <= 4'h9 && $past(rst_sync_n) |->
        tuning_gain_pct == 7'(($past(tuning_config[7:4]) + 4'h1) * 7'h0A)) // [R1]
        else $error("gain scale wrong");
    a_blank_delay: assert property ($past(rst_sync_n) |->
        blank_delay_ns == 10'($past(sense_and_pin_config[15:11]) * 10'h020)) // [R7]
        else $error("blanking delay wrong");
    a_fault_count: assert property ($rose(current_fault) |->
        $past(viol_run) + 4'h1 >= {$past(sense_and_pin_config[10:8]), 1'b1}) // [R8]
        else $error("current fault raised early");
    a_spread_off: assert property (!operating_options[8] |=> !shutdown_request) // [R16]
        else $error("shutdown without fault spreading");
    a_sync_enabled: assert property (device_enabled |=> ##1 !sync_timed_out) // [R14]
        else $error("switch clock timed out while enabled");
    a_pg_opendrain: assert property (!sense_and_pin_config[1] && pg_ready |=>
        !output_ok_pin_oe || $past(sense_and_pin_config[1]) || !$past(pg_ready)) // [R11]
        else $error("open-drain power-good driven high");
    a_lowside_off: assert property (device_enabled |=> !lowside_drive_on) // [R19]
        else $error("low-side drive on while enabled");
endmodule
`default_nettype wire

// ---- bench/pmbus_host_model.sv ----
// Host model issuing one decoded PMBus command per transfer.
// Assumes the bank takes a command at the rising core_clk edge.
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
    input  wire logic   core_clk,
    output logic        cmd_valid,
    output logic        cmd_write,
    output logic [7:0]  cmd_code,
    output logic [15:0] cmd_wdata
);
    initial {cmd_valid, cmd_write, cmd_code, cmd_wdata} = 26'h0000000;
    // Held for one taking edge, then released with inverted data
    task automatic issue(input logic wr, input logic [7:0] code, input logic [15:0] data);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code  <= code;
        cmd_wdata <= data;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        cmd_wdata <= ~data;
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the regulator configuration bank.
// Assumes pmbus_host_model drives the command port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        core_clk;
    logic        rst_n;
    logic [11:0] sts;
    wire logic   cmd_valid;
    wire logic   cmd_write;
    wire logic [7:0]  cmd_code;
    wire logic [15:0] cmd_wdata;
    int          err_total = 0;
    int          checked = 0;
    int          cycles = 0;
    int          starts = 0;
    logic [15:0] r;
    logic [1:0]  m_exp = 2'h0;
    logic [1:0]  s_exp = 2'h0;
    logic        d0b;
    logic [7:0]  codes [5] = '{8'hBC, 8'hBF, 8'hD0, 8'hD1, 8'hD2};
    logic [2:0]  nf [3] = '{3'h0, 3'h3, 3'h7};
    pmbus_host_model host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
    regulator_cfg #(.SYNC_OFF_CYCLES(20), .SECOND_CYCLES(10)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(), .rsp_rdata(),
        .cmd_unsupported(), .device_enabled(sts[0]), .ramp_up_done(sts[1]), .in_ramp(sts[2]),
        .ramping_down(sts[3]), .below_uv_threshold(sts[4]), .pg_delay_done(sts[5]),
        .tuning_done(sts[6]), .sense_strobe(sts[7]), .sense_violation(sts[8]),
        .group_fault(sts[9]), .int_switch_clk(sts[10]), .meas_read(sts[11]), .tuning_start(),
        .tuning_gain_pct(), .deadtime_hl_ns(), .deadtime_lh_ns(), .blank_delay_ns(),
        .current_fault(), .sense_method(), .nonlinear_transient_response(),
        .output_ok_pin_out(), .output_ok_pin_oe(), .sync_pin_out(), .sync_pin_oe(),
        .min_duty_num(), .min_duty_active(), .output_hiz(), .vin_correction_on(),
        .shutdown_request(), .use_ext_clock(), .lowside_drive_on(), .standby_mode(),
        .comm_logic_fault(), .share_id(), .share_count_m1(), .share_pos_m1(), .share_member());
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        host.issue(1'b1, code, data);
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic bad);
        host.issue(1'b0, code, 16'h0000);
        #1;
        chk("rsp_rdata", dut.rsp_rdata, exp);
        chk("cmd_unsupported", 16'(dut.cmd_unsupported), 16'(bad));
        if (!bad) chk("rsp_valid", 16'(dut.rsp_valid), 16'h0001);
    endtask
    task automatic strobe(input logic v);
        @(posedge core_clk);
        sts[8:7] <= {v, 1'b1};
        @(posedge core_clk);
        sts[8:7] <= 2'b00;
    endtask
    task automatic cnt_starts(input int n, input int exp);
        int s0;
        s0 = starts;
        repeat (n) @(posedge core_clk);
        #1;
        chk("periodic", 16'(starts - s0), 16'(exp));
    endtask
    task automatic wrap_up;
        if (err_total == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    always @(posedge core_clk) if (dut.tuning_start === 1'b1) starts++;
    initial begin
        rst_n = 1'b0;
        sts = 12'h001;
        r = 16'($urandom(68326));
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("vin_correction_on", 16'(dut.vin_correction_on), 16'h0001);
        foreach (codes[i]) rd(codes[i], 16'h0000, 1'b0);
        rd(8'hD3, 16'h0000, 1'b1);
        rd(8'hBD, 16'h0000, 1'b1);
        for (int g = 0; g < 16; g++) begin
            wr(8'hBC, 16'(g << 4));
            chk("gain", 16'(dut.tuning_gain_pct), 16'((g > 9 ? 10 : g + 1) * 10));
        end
        host.issue(1'b1, 8'hBD, 16'hFFFF);
        wr(8'hBC, 16'h0091);
        chk("starts_off", 16'(starts), 16'h0000);
        host.issue(1'b1, 8'hBD, 16'h0000);
        repeat (3) @(posedge core_clk);
        chk("starts_on", 16'(starts), 16'h0001);
        foreach (nf[k]) begin
            wr(8'hD0, {5'h00, nf[k], 8'h00});
            for (int j = 0; j < 2 * nf[k]; j++) strobe(1'b1);
            repeat (2) @(posedge core_clk);
            #1;
            chk("fault_early", 16'(dut.current_fault), 16'h0000);
            strobe(1'b1);
            @(posedge core_clk);
            #1;
            chk("fault_run", 16'(dut.current_fault), 16'h0001);
            strobe(1'b0);
        end
        for (int i = 0; i < 24; i++) begin
            @(posedge core_clk);
            sts <= 12'($urandom) & 12'hE7F;
            r = 16'($urandom);
            wr(8'hD0, r);
            d0b = r[0];
            if (r[5:4] != 2'h3) m_exp = r[5:4];
            chk("blank", 16'(dut.blank_delay_ns), 16'(r[15:11] * 32));
            chk("method", 16'(dut.sense_method), 16'(m_exp));
            if (!sts[0]) chk("pg_nlr", 16'({dut.nonlinear_transient_response,
                dut.output_ok_pin_out, dut.output_ok_pin_oe}),
                16'({r[3], 2'b01}));
            rd(8'hD0, r, 1'b0);
            r = 16'($urandom);
            wr(8'hD1, r);
            if (r[1:0] != 2'h2) s_exp = r[1:0];
            chk("min_duty", 16'(dut.min_duty_num), 16'(r[15:14] + 3'h1));
            chk("vin_corr", 16'(dut.vin_correction_on), 16'(!r[9]));
            chk("ext_clk", 16'(dut.use_ext_clock), 16'(r[6]));
            chk("lowside", 16'(dut.lowside_drive_on), 16'(r[2] && !sts[0]));
            chk("standby", 16'(dut.standby_mode), 16'(s_exp));
            if (sts[0] || !r[11]) chk("sync_pin", 16'({dut.sync_pin_out, dut.sync_pin_oe}),
                16'({sts[10], r[5] && !r[6] && (d0b || !sts[10])}));
            chk("opts", 16'({dut.min_duty_active, dut.output_hiz, dut.shutdown_request,
                dut.comm_logic_fault}), 16'({r[13] && sts[2], r[12] && sts[3] && !sts[4],
                r[8] && sts[9], sts[11] && !sts[0] && !s_exp}));
            rd(8'hD1, r, 1'b0);
            r = {3'h0, 5'($urandom), 8'($urandom)};
            wr(8'hD2, r);
            chk("share_id", 16'(dut.share_id), 16'(r[15:8]));
            chk("share", 16'({dut.share_count_m1, dut.share_pos_m1, dut.share_member}),
                16'({r[7:5], r[4:2], r[0]}));
            r = {8'($urandom_range(70) - 10), 8'($urandom_range(70) - 10)};
            wr(8'hBF, r);
            chk("deadtime", {dut.deadtime_hl_ns, dut.deadtime_lh_ns}, r);
        end
        @(posedge core_clk);
        sts <= 12'h001;
        wr(8'hD2, 16'h0000);
        wr(8'hBC, 16'h0002);
        cnt_starts(100, 10);
        wr(8'hD2, 16'h0001);
        cnt_starts(100, 0);
        wr(8'hD2, 16'h0000);
        wr(8'hBC, 16'h0003);
        cnt_starts(1200, 2);
        wr(8'hD0, 16'h0001);
        wr(8'hD1, 16'h0820);
        @(posedge core_clk);
        sts <= 12'h000;
        repeat (10) @(posedge core_clk);
        #1;
        chk("sync_hold", 16'(dut.sync_pin_oe), 16'h0001);
        repeat (15) @(posedge core_clk);
        #1;
        chk("sync_off", 16'(dut.sync_pin_oe), 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
